// File: hdl/racw_core.sv
// Command interpreter for acknowledge wait, background abort and immediate commands
`timescale 1ns/1ps
// Notes on behaviour
// - Ack wait holds suspended receiver until start
// - Background receive continues; search expected sequence
// - Queue ack only when accept flag set
// - Good checksum ends; bad continues search
// - Pending bit selects ack pending or received
// - End trigger gives timeout, result false
// - Stop gives stopped; abort gives aborted
// - Background end or bad parameter abort
// - Write status, pulse foreground done interrupt
// - True starts chained command, else idle
// - Background abort waits trigger, then succeeds
// - Generic stop/abort also end background
// - Modify CCA replaces threshold and options
// - Modify CCA needs background, else context error
// - Illegal values give parameter error, else done
// - Filter update applies when filtering restarts
// - Reply enables apply at reception end
// - Filter/source need receive operation, else error
// - List select zero long, one short
// - Enable bit and pending value per entry
// - Missing entry index gives parameter error
// - Foreground abort leaves background running
// - Foreground abort always reports done
// - Foreground stop graceful, always reports done
module racw_core (
  // Clock and reset
  input  wire logic                      sys_clk,
  input  wire logic                      rst,
  // Foreground command start
  input  wire logic                      fg_start,
  input  wire logic [1:0]                fg_kind,
  input  wire logic [7:0]                expected_sequence,
  input  wire logic                      fg_param_bad,
  input  wire logic                      next_command_valid,
  // Triggers (asynchronous)
  input  wire logic                      start_trigger,
  input  wire logic                      stop_trigger,
  // Background state
  input  wire logic                      bg_rx_active,
  input  wire logic                      bg_scan_active,
  input  wire logic                      bg_ended,
  input  wire logic                      tx_suspended,
  // Received frame report
  input  wire logic                      ack_seen,
  input  wire logic [7:0]                ack_sequence,
  input  wire logic                      ack_crc_ok,
  input  wire logic                      ack_pending_bit,
  input  wire logic                      rx_frame_end,
  input  wire logic                      filter_restart,
  // Immediate commands
  input  wire logic                      imm_valid,
  input  wire logic [2:0]                imm_code,
  input  wire logic [7:0]                new_energy_threshold,
  input  wire logic [7:0]                new_check_options,
  input  wire logic [racw_pkg::FILT_W-1:0]  new_filter_options,
  input  wire logic [racw_pkg::KINDS_W-1:0] new_frame_kinds,
  input  wire logic                      entry_list_select,
  input  wire logic [3:0]                entry_index,
  input  wire logic                      entry_enable_bit,
  input  wire logic                      pending_value,
  // Command answers
  output logic [7:0]                     command_status_reg,
  output logic                           command_status_valid,
  output logic [15:0]                    fg_status,
  output logic [1:0]                     fg_result,
  output logic                           foreground_done_irq,
  output logic                           start_next_command,
  output logic                           fg_busy,
  // Background control
  output logic                           bg_rx_hold,
  output logic                           bg_abort,
  output logic                           ack_to_queue,
  // Running configuration
  output logic [7:0]                     channel_energy_threshold,
  output logic [7:0]                     channel_check_options,
  output logic [racw_pkg::FILT_W-1:0]    filter_options,
  output logic [racw_pkg::KINDS_W-1:0]   accepted_frame_kinds,
  output logic                           auto_reply_enable,
  output logic                           slotted_reply_enable,
  output logic [racw_pkg::LONG_ENTRIES-1:0]  long_entry_enable,
  output logic [racw_pkg::LONG_ENTRIES-1:0]  long_entry_pending,
  output logic [racw_pkg::SHORT_ENTRIES-1:0] short_entry_enable,
  output logic [racw_pkg::SHORT_ENTRIES-1:0] short_entry_pending
);
  import racw_pkg::*;

  typedef enum logic [1:0] {RACW_IDLE, RACW_WAIT_START, RACW_ACK_RUN} racw_state_e;

  racw_state_e state;
  racw_state_e next_state;
  logic        ack_kind;
  logic [1:0]  sync_start;
  logic [1:0]  sync_stop;
  logic [15:0] filt_pending;
  logic [7:0]  kinds_pending;
  logic        filt_armed;
  logic        reply_armed;
  logic        auto_pending;
  logic        slot_pending;

  // Triggers come from the timer domain, so they are double sampled
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sync_start <= 2'h0;
      sync_stop  <= 2'h0;
    end else begin
      sync_start <= {sync_start[0], start_trigger};
      sync_stop  <= {sync_stop[0], stop_trigger};
    end
  end

  wire trig_start = sync_start[1];
  wire trig_stop  = sync_stop[1];

  // Immediate command decode
  wire imm_cca   = imm_valid && (imm_code == IMM_MOD_CCA);
  wire imm_filt  = imm_valid && (imm_code == IMM_MOD_FILT);
  wire imm_src   = imm_valid && (imm_code == IMM_MOD_SRC);
  wire stop_fg   = imm_valid && (imm_code == IMM_STOP_FG);
  wire abort_fg  = imm_valid && (imm_code == IMM_ABORT_FG);
  wire stop_gen  = imm_valid && (imm_code == IMM_STOP);
  wire abort_gen = imm_valid && (imm_code == IMM_ABORT);
  wire any_stop  = stop_fg || stop_gen;
  wire any_abort = abort_fg || abort_gen;
  wire running   = (state != RACW_IDLE);
  wire bg_any    = bg_rx_active || bg_scan_active;
  wire cca_bad   = (new_check_options & ~CCA_OPT_LEGAL_MASK) != 8'h00;
  wire src_bad   = (entry_list_select == LIST_LONG) ? (entry_index >= LONG_ENTRIES_N)
                                                    : (entry_index >= SHORT_ENTRIES_N);
  wire cca_ok    = imm_cca && bg_any && !cca_bad;
  wire filt_ok   = imm_filt && bg_rx_active;
  wire src_ok    = imm_src && bg_rx_active && !src_bad;

  // Command status answer: context, then parameter, then illegal code, then done
  wire [7:0] imm_answer =
    (imm_cca && !bg_any)                       ? RESULT_WRONG_CONTEXT :
    ((imm_filt || imm_src) && !bg_rx_active)   ? RESULT_WRONG_CONTEXT :
    (imm_cca && cca_bad)                       ? RESULT_BAD_PARAMETER :
    (imm_src && src_bad)                       ? RESULT_BAD_PARAMETER :
    (imm_code == 3'h0)                         ? RESULT_ILLEGAL_CMD :
                                                 RESULT_DONE;

  // Acknowledge match: expected sequence and good checksum
  wire ack_match = ack_seen && (ack_sequence == expected_sequence);
  wire ack_good  = ack_match && ack_crc_ok;

  // End cause priority within a running operation
  logic        end_now;
  logic [15:0] end_status;
  logic [1:0]  end_result;
  always_comb begin
    {end_now, end_status, end_result} = {1'b0, STATUS_IDLE, RES_FALSE};
    next_state = state;
    case (state)
      RACW_IDLE: begin
        if (fg_start && fg_param_bad) begin
          {end_now, end_status, end_result} = {1'b1, STATUS_BAD_PARAMETER, RES_ABORT};
        end else if (fg_start && (fg_kind == FG_RX_ACK || fg_kind == FG_ABORT_BG)) begin
          next_state = RACW_WAIT_START;
        end
      end
      RACW_WAIT_START: begin
        if (any_abort) begin
          {end_now, end_status, end_result} = {1'b1, STATUS_ABORT, RES_ABORT};
        end else if (any_stop) begin
          {end_now, end_status, end_result} = {1'b1, STATUS_STOPPED, RES_FALSE};
        end else if (ack_kind && bg_ended) begin
          {end_now, end_status, end_result} = {1'b1, STATUS_BACKGROUND_ENDED, RES_ABORT};
        end else if (trig_start && !ack_kind) begin
          {end_now, end_status, end_result} = {1'b1, STATUS_OK, RES_TRUE};
        end else if (trig_start) begin
          next_state = RACW_ACK_RUN;
        end
      end
      RACW_ACK_RUN: begin
        if (any_abort) begin
          {end_now, end_status, end_result} = {1'b1, STATUS_ABORT, RES_ABORT};
        end else if (any_stop) begin
          {end_now, end_status, end_result} = {1'b1, STATUS_STOPPED, RES_FALSE};
        end else if (bg_ended) begin
          {end_now, end_status, end_result} = {1'b1, STATUS_BACKGROUND_ENDED, RES_ABORT};
        end else if (ack_good) begin
          end_now    = 1'b1;
          end_status = ack_pending_bit ? STATUS_ACK_PENDING : STATUS_ACK;
          end_result = ack_pending_bit ? RES_TRUE : RES_FALSE;
        end else if (trig_stop) begin
          {end_now, end_status, end_result} = {1'b1, STATUS_TIMEOUT, RES_FALSE};
        end
      end
      default: next_state = RACW_IDLE;
    endcase
    if (end_now) begin
      next_state = RACW_IDLE;
    end
  end

  wire end_now_cmd   = any_abort || any_stop;
  wire bg_abort_fire = (state == RACW_WAIT_START) && !ack_kind && trig_start && !end_now_cmd;

  // Foreground sequencer
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state    <= RACW_IDLE;
      ack_kind <= 1'b0;
    end else begin
      state <= next_state;
      if (fg_start && state == RACW_IDLE) begin
        ack_kind <= (fg_kind == FG_RX_ACK);
      end
    end
  end

  // End report and background control outputs
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      fg_status           <= STATUS_IDLE;
      fg_result           <= RES_FALSE;
      foreground_done_irq <= 1'b0;
      start_next_command  <= 1'b0;
      fg_busy             <= 1'b0;
      bg_rx_hold          <= 1'b0;
      bg_abort            <= 1'b0;
      ack_to_queue        <= 1'b0;
    end else begin
      foreground_done_irq <= end_now;
      start_next_command  <= end_now && (end_result == RES_TRUE) && next_command_valid;
      if (end_now) begin
        fg_status <= end_status;
        fg_result <= end_result;
      end
      fg_busy      <= (next_state != RACW_IDLE);
      // A suspended receiver stays held until the start trigger of an ack wait
      bg_rx_hold   <= (next_state == RACW_WAIT_START) && tx_suspended
                      && ((state == RACW_IDLE) ? (fg_kind == FG_RX_ACK) : ack_kind);
      bg_abort     <= bg_abort_fire || stop_gen || abort_gen;
      ack_to_queue <= ack_seen && accepted_frame_kinds[KIND_ACK_BIT];
    end
  end

  // Command status register
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      command_status_reg   <= 8'h00;
      command_status_valid <= 1'b0;
    end else begin
      command_status_valid <= imm_valid;
      if (imm_valid) begin
        command_status_reg <= imm_answer;
      end
    end
  end

  // CCA settings take effect at once for future evaluations
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      channel_energy_threshold <= THRESHOLD_RESET;
      channel_check_options    <= CCA_OPT_RESET;
    end else if (cca_ok) begin
      channel_energy_threshold <= new_energy_threshold;
      channel_check_options    <= new_check_options;
    end
  end

  // Filter values are staged; the filter restart and reception end commit them
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      filt_pending         <= FILT_RESET;
      kinds_pending        <= KINDS_RESET;
      filt_armed           <= 1'b0;
      reply_armed          <= 1'b0;
      auto_pending         <= 1'b0;
      slot_pending         <= 1'b0;
      filter_options       <= FILT_RESET;
      accepted_frame_kinds <= KINDS_RESET;
      auto_reply_enable    <= 1'b0;
      slotted_reply_enable <= 1'b0;
    end else begin
      if (filt_ok) begin
        filt_pending  <= new_filter_options;
        kinds_pending <= new_frame_kinds;
        auto_pending  <= new_filter_options[AUTO_BIT];
        slot_pending  <= new_filter_options[SLOT_BIT];
      end
      // A new command in the commit cycle re-arms, so it is not lost
      filt_armed  <= filt_ok || (filt_armed && !filter_restart);
      reply_armed <= filt_ok || (reply_armed && !rx_frame_end);
      if (filter_restart && filt_armed) begin
        filter_options       <= filt_pending;
        accepted_frame_kinds <= kinds_pending;
      end
      if (rx_frame_end && reply_armed) begin
        auto_reply_enable    <= auto_pending;
        slotted_reply_enable <= slot_pending;
      end
    end
  end

  // Source-match entries; the host edits addresses only while disabled
  genvar gi;
  generate
    for (gi = 0; gi < SHORT_ENTRIES; gi++) begin : g_short
      wire hit_s = src_ok && (entry_list_select == LIST_SHORT) && (entry_index == 4'(gi));
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          short_entry_enable[gi]  <= 1'b0;
          short_entry_pending[gi] <= 1'b0;
        end else if (hit_s) begin
          short_entry_enable[gi]  <= entry_enable_bit;
          short_entry_pending[gi] <= pending_value;
        end
      end
      if (gi < LONG_ENTRIES) begin : g_long
        wire hit_l = src_ok && (entry_list_select == LIST_LONG) && (entry_index == 4'(gi));
        always_ff @(posedge sys_clk or posedge rst) begin
          if (rst) begin
            long_entry_enable[gi]  <= 1'b0;
            long_entry_pending[gi] <= 1'b0;
          end else if (hit_l) begin
            long_entry_enable[gi]  <= entry_enable_bit;
            long_entry_pending[gi] <= pending_value;
          end
        end
      end
    end
  endgenerate

  // Checks
  sequence ack_good_s;
    (state == RACW_ACK_RUN) && !end_now_cmd && !bg_ended && ack_good;
  endsequence

  ack_end_a: assert property (@(posedge sys_clk) disable iff (rst)
    ack_good_s |=> foreground_done_irq && (fg_result == ($past(ack_pending_bit) ? RES_TRUE : RES_FALSE)))
    else $error("ack end result wrong");
  done_irq_a: assert property (@(posedge sys_clk) disable iff (rst)
    end_now |=> foreground_done_irq && fg_status == $past(end_status))
    else $error("done interrupt missing");
  chain_a: assert property (@(posedge sys_clk) disable iff (rst)
    start_next_command |-> fg_result == RES_TRUE)
    else $error("chain without true result");
  timeout_a: assert property (@(posedge sys_clk) disable iff (rst)
    (state == RACW_ACK_RUN && trig_stop && !imm_valid && !bg_ended && !ack_good)
      |=> fg_status == STATUS_TIMEOUT && state == RACW_IDLE)
    else $error("timeout not reported");
  fg_abort_bg_a: assert property (@(posedge sys_clk) disable iff (rst)
    (abort_fg || stop_fg) |=> !bg_abort)
    else $error("foreground command hit background");
  cca_ctx_a: assert property (@(posedge sys_clk) disable iff (rst)
    imm_cca && !bg_any |=> command_status_reg == RESULT_WRONG_CONTEXT
      && $stable(channel_energy_threshold))
    else $error("cca context error missing");
  filt_ctx_a: assert property (@(posedge sys_clk) disable iff (rst)
    (imm_filt || imm_src) && !bg_rx_active |=> command_status_reg == RESULT_WRONG_CONTEXT)
    else $error("filter context error missing");
  src_range_a: assert property (@(posedge sys_clk) disable iff (rst)
    imm_src && bg_rx_active && src_bad |=> command_status_reg == RESULT_BAD_PARAMETER)
    else $error("bad entry index accepted");
  abort_done_a: assert property (@(posedge sys_clk) disable iff (rst)
    (abort_fg || stop_fg) |=> command_status_reg == RESULT_DONE && (state == RACW_IDLE || !$past(running)))
    else $error("abort not done");
  status_pulse_a: assert property (@(posedge sys_clk) disable iff (rst)
    command_status_valid == $past(imm_valid))
    else $error("status valid pulse wrong");
endmodule

// File: hdl/racw_pkg.sv
// Package of codes and layouts for the radio acknowledge-wait and immediate command block
package racw_pkg;
  // Foreground operation kinds
  localparam logic [1:0] FG_RX_ACK   = 2'h1;
  localparam logic [1:0] FG_ABORT_BG = 2'h2;
  // Immediate command codes
  localparam logic [2:0] IMM_MOD_CCA  = 3'h1;
  localparam logic [2:0] IMM_MOD_FILT = 3'h2;
  localparam logic [2:0] IMM_MOD_SRC  = 3'h3;
  localparam logic [2:0] IMM_ABORT_FG = 3'h4;
  localparam logic [2:0] IMM_STOP_FG  = 3'h5;
  localparam logic [2:0] IMM_STOP     = 3'h6;
  localparam logic [2:0] IMM_ABORT    = 3'h7;
  // Command status register results
  localparam logic [7:0] RESULT_DONE          = 8'h01;
  localparam logic [7:0] RESULT_WRONG_CONTEXT = 8'h81;
  localparam logic [7:0] RESULT_BAD_PARAMETER = 8'h82;
  localparam logic [7:0] RESULT_ILLEGAL_CMD   = 8'h83;
  // Foreground end status codes (two bytes)
  localparam logic [15:0] STATUS_IDLE               = 16'h0000;
  localparam logic [15:0] STATUS_OK                 = 16'h2400;
  localparam logic [15:0] STATUS_ACK                = 16'h2401;
  localparam logic [15:0] STATUS_ACK_PENDING        = 16'h2402;
  localparam logic [15:0] STATUS_TIMEOUT            = 16'h2403;
  localparam logic [15:0] STATUS_STOPPED            = 16'h2404;
  localparam logic [15:0] STATUS_ABORT              = 16'h2405;
  localparam logic [15:0] STATUS_BACKGROUND_ENDED   = 16'h2406;
  localparam logic [15:0] STATUS_BAD_PARAMETER      = 16'h2800;
  // Operation results
  localparam logic [1:0] RES_FALSE = 2'h0;
  localparam logic [1:0] RES_TRUE  = 2'h1;
  localparam logic [1:0] RES_ABORT = 2'h2;
  // Source-match lists
  localparam int          LONG_ENTRIES  = 4;
  localparam int          SHORT_ENTRIES = 8;
  localparam logic [3:0]  LONG_ENTRIES_N  = 4'h4;
  localparam logic [3:0]  SHORT_ENTRIES_N = 4'h8;
  localparam logic        LIST_LONG     = 1'b0;
  localparam logic        LIST_SHORT    = 1'b1;
  // Field widths and positions
  localparam int          FILT_W       = 16;
  localparam int          AUTO_BIT     = 0;
  localparam int          SLOT_BIT     = 1;
  localparam int          KINDS_W      = 8;
  localparam int          KIND_ACK_BIT = 2;
  localparam logic [7:0]  CCA_OPT_LEGAL_MASK = 8'h7F;
  // Reset values
  localparam logic [7:0]  THRESHOLD_RESET = 8'hA6;
  localparam logic [7:0]  CCA_OPT_RESET   = 8'h00;
  localparam logic [15:0] FILT_RESET      = 16'h0000;
  localparam logic [7:0]  KINDS_RESET     = 8'hFF;
endpackage

// File: tb/racw_bg_model.sv
// Background receive model standing at the far side of the command block
`timescale 1ns/1ps
module racw_bg_model (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rst,
  // Control from the bench and the block
  input  wire logic bg_on,
  input  wire logic bg_abort,
  input  wire logic bg_off,
  // Background state
  output logic      bg_rx_active,
  output logic      bg_ended
);
  // An abort wins over a start in the same cycle, so a receiver that is told to stop never lingers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bg_rx_active <= 1'b0;
      bg_ended     <= 1'b0;
    end else begin
      // The bench may also end reception on its own, as a finished receive would
      bg_ended     <= bg_rx_active & (bg_abort | bg_off);
      bg_rx_active <= (bg_abort | bg_off) ? 1'b0 : (bg_rx_active | bg_on);
    end
  end
endmodule

// File: tb/racw_core_tb_top.sv
// Self-checking bench for the acknowledge-wait and immediate command block
`timescale 1ns/1ps
module racw_core_tb_top;
  import racw_pkg::*;
  logic        sys_clk, rst, fg_start, fg_param_bad, next_command_valid, start_trigger, stop_trigger;
  logic        bg_rx_active, bg_scan_active, bg_ended, tx_suspended, bg_on, ack_seen, ack_crc_ok;
  logic        ack_pending_bit, rx_frame_end, filter_restart, imm_valid, entry_list_select, entry_enable_bit;
  logic        pending_value, command_status_valid, foreground_done_irq, start_next_command, fg_busy;
  logic        bg_rx_hold, bg_abort, ack_to_queue, auto_reply_enable, slotted_reply_enable, nxt_seen, q_seen;
  logic        done_seen, bg_off;
  logic [1:0]  fg_kind, fg_result;
  logic [2:0]  imm_code;
  logic [3:0]  entry_index, long_entry_enable, long_entry_pending;
  logic [7:0]  expected_sequence, ack_sequence, new_energy_threshold, new_check_options, new_frame_kinds;
  logic [7:0]  command_status_reg, channel_energy_threshold, channel_check_options, accepted_frame_kinds;
  logic [7:0]  short_entry_enable, short_entry_pending;
  logic [15:0] new_filter_options, fg_status, filter_options;
  int          failures, num_checks;

  racw_core     u_dut (.*);
  racw_bg_model u_bg (.*);

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Pulses are sampled just after the edge, once the registered outputs have settled
  always @(posedge sys_clk) begin
    #1;
    if (start_next_command === 1'b1) nxt_seen = 1'b1;
    if (ack_to_queue === 1'b1) q_seen = 1'b1;
    if (foreground_done_irq === 1'b1) done_seen = 1'b1;
  end

  task automatic stop_test();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Request is raised after a falling edge and dropped before a second rising edge can take it again
  task automatic imm(input logic [2:0] code);
    @(negedge sys_clk) imm_valid = 1'b1;
    imm_code = code;
    @(negedge sys_clk) imm_valid = 1'b0;
    @(posedge sys_clk) #1;
  endtask

  task automatic fg(input logic [1:0] kind);
    @(negedge sys_clk) fg_kind = kind;
    fg_start = 1'b1;
    nxt_seen = 1'b0;
    done_seen = 1'b0;
    @(negedge sys_clk) fg_start = 1'b0;
  endtask

  task automatic bg_start();
    @(negedge sys_clk) bg_on = 1'b1;
    @(negedge sys_clk) bg_on = 1'b0;
  endtask

  task automatic ack(input logic [7:0] seq, input logic crc);
    @(negedge sys_clk) ack_seen = 1'b1;
    ack_sequence = seq;
    ack_crc_ok = crc;
    @(negedge sys_clk) ack_seen = 1'b0;
  endtask

  task automatic wait_done(input logic [15:0] st, input logic [1:0] res);
    int i;
    // The done pulse may already have passed while a command was being issued
    for (i = 0; i < 60 && foreground_done_irq !== 1'b1 && done_seen !== 1'b1; i++) @(posedge sys_clk) #1;
    if (i == 60) begin
      failures++;
      stop_test();
    end
    check(fg_status, st);
    check(fg_result, res);
    @(negedge sys_clk) start_trigger = 1'b0;
    stop_trigger = 1'b0;
    fg_param_bad = 1'b0;
    tx_suspended = 1'b0;
    repeat (3) @(posedge sys_clk);
  endtask

  initial begin
    {fg_start, fg_param_bad, next_command_valid, start_trigger, stop_trigger, bg_scan_active} = '0;
    {tx_suspended, bg_on, ack_seen, ack_crc_ok, ack_pending_bit, rx_frame_end, filter_restart} = '0;
    {imm_valid, entry_list_select, entry_enable_bit, pending_value, fg_kind, imm_code, entry_index} = '0;
    {expected_sequence, ack_sequence, new_energy_threshold, new_check_options, new_frame_kinds} = '0;
    {new_filter_options, nxt_seen, q_seen, done_seen, bg_off, failures, num_checks} = '0;
    rst = 1'b1;
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk) rst = 1'b0;
    imm(IMM_MOD_CCA);
    check(command_status_reg, RESULT_WRONG_CONTEXT);
    check(channel_energy_threshold, THRESHOLD_RESET);
    bg_start();
    new_check_options = 8'h80;
    imm(IMM_MOD_CCA);
    check(command_status_reg, RESULT_BAD_PARAMETER);
    {new_energy_threshold, new_check_options} = 16'h5512;
    imm(IMM_MOD_CCA);
    check(command_status_reg, RESULT_DONE);
    check({channel_energy_threshold, channel_check_options}, 16'h5512);
    {new_filter_options, new_frame_kinds} = 24'h000304;
    imm(IMM_MOD_FILT);
    check(command_status_reg, RESULT_DONE);
    check(accepted_frame_kinds, KINDS_RESET);
    @(negedge sys_clk) filter_restart = 1'b1;
    @(negedge sys_clk) {filter_restart, rx_frame_end} = 2'h1;
    check(filter_options, 16'h0003);
    check(accepted_frame_kinds, 8'h04);
    check({slotted_reply_enable, auto_reply_enable}, 2'h0);
    @(negedge sys_clk) rx_frame_end = 1'b0;
    check({slotted_reply_enable, auto_reply_enable}, 2'h3);
    // Index 4 is past the end of the long list and is refused; index 3 then takes enable and pending
    {entry_index, entry_enable_bit, pending_value} = 6'h13;
    imm(IMM_MOD_SRC);
    check(command_status_reg, RESULT_BAD_PARAMETER);
    entry_index = 4'h3;
    imm(IMM_MOD_SRC);
    check({long_entry_enable, long_entry_pending}, 8'h88);
    {entry_list_select, entry_index, pending_value} = {LIST_SHORT, 4'h7, 1'b0};
    imm(IMM_MOD_SRC);
    check({short_entry_enable, short_entry_pending}, 16'h8000);
    {expected_sequence, next_command_valid, ack_pending_bit} = 10'h16B;
    fg(FG_RX_ACK);
    start_trigger = 1'b1;
    repeat (6) @(posedge sys_clk);
    ack(8'h5B, 1'b1);
    ack(8'h5A, 1'b0);
    check(fg_busy, 1'b1);
    ack(8'h5A, 1'b1);
    wait_done(STATUS_ACK_PENDING, RES_TRUE);
    check(nxt_seen, 1'b1);
    check(q_seen, 1'b1);
    @(negedge sys_clk) tx_suspended = 1'b1;
    fg(FG_RX_ACK);
    check(bg_rx_hold, 1'b1);
    start_trigger = 1'b1;
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk) stop_trigger = 1'b1;
    check(bg_rx_hold, 1'b0);
    wait_done(STATUS_TIMEOUT, RES_FALSE);
    check(nxt_seen, 1'b0);
    fg(FG_RX_ACK);
    start_trigger = 1'b1;
    repeat (5) @(posedge sys_clk);
    imm(IMM_ABORT_FG);
    check(command_status_reg, RESULT_DONE);
    wait_done(STATUS_ABORT, RES_ABORT);
    check(bg_rx_active, 1'b1);
    imm(IMM_STOP_FG);
    check(command_status_reg, RESULT_DONE);
    fg(FG_ABORT_BG);
    start_trigger = 1'b1;
    wait_done(STATUS_OK, RES_TRUE);
    check(bg_rx_active, 1'b0);
    check(nxt_seen, 1'b1);
    imm(IMM_MOD_FILT);
    check(command_status_reg, RESULT_WRONG_CONTEXT);
    @(negedge sys_clk) bg_scan_active = 1'b1;
    imm(IMM_MOD_CCA);
    check(command_status_reg, RESULT_DONE);
    imm(IMM_MOD_SRC);
    check(command_status_reg, RESULT_WRONG_CONTEXT);
    @(negedge sys_clk) bg_scan_active = 1'b0;
    fg_param_bad = 1'b1;
    fg(FG_RX_ACK);
    wait_done(STATUS_BAD_PARAMETER, RES_ABORT);
    bg_start();
    fg(FG_ABORT_BG);
    imm(IMM_STOP);
    wait_done(STATUS_STOPPED, RES_FALSE);
    check(bg_rx_active, 1'b0);
    bg_start();
    fg(FG_RX_ACK);
    start_trigger = 1'b1;
    repeat (5) @(posedge sys_clk);
    @(negedge sys_clk) bg_off = 1'b1;
    @(negedge sys_clk) bg_off = 1'b0;
    wait_done(STATUS_BACKGROUND_ENDED, RES_ABORT);
    stop_test();
  end
endmodule
